// [sim/sarc_partner.sv]
// comparator, input pins and processor acceptance around the converter
`timescale 1ns/10ps
module sarc_partner (
   input wire logic i_clk, // core clock
   input wire logic [9:0] i_dac, // comparison code
   input wire logic [2:0] i_ch, // converted pin
   input wire logic [7:0] i_en, // pins usable as input
   input wire logic i_req, // interrupt request
   input wire logic i_ack_on, // processor takes requests
   input wire logic [9:0] i_vin [8], // input level of each pin as a code
   output logic o_above, // input above comparison
   output logic o_ack // acceptance pulse
);
   // comparison sits half a step below code n
   assign o_above = i_en[i_ch] && (i_dac <= i_vin[i_ch]);
   initial o_ack = 1'b0;
   // one pulse, then one low cycle; a request still high gets another pulse
   always @(posedge i_clk) o_ack <= i_ack_on && i_req && !o_ack;
endmodule : sarc_partner

// [sim/sarc_top_assertions.sv]
// concurrent checks on the converter control ports
`timescale 1ns/10ps
module sarc_top_assertions (
   input wire logic I_CORE_CLK, // clock
   input wire logic I_RST, // reset
   input wire logic [5:0] I_AVS_ADDRESS, // address
   input wire logic I_AVS_WRITE, // write
   input wire logic [31:0] I_AVS_WRITEDATA, // write data
   input wire logic [3:0] I_AVS_BYTEENABLE, // lanes
   input wire logic O_AVS_WAITREQUEST, // stall
   input wire logic I_CMP_ABOVE, // comparator
   input wire logic [2:0] I_IPL, // processor level
   input wire logic I_IRQ_DISABLE, // disable flag
   input wire logic I_INT_ACK, // acceptance
   input wire logic O_INT_REQ, // request
   input wire logic [2:0] O_INT_LEVEL, // level
   input wire logic [9:0] O_DAC_CODE, // approximation
   input wire logic [7:0] O_ANALOG_EN, // usable pins
   input wire logic [7:0] O_FORCED_OUT, // forced pins
   input wire logic [7:0] O_PORT_DIR, // directions
   input wire logic O_BUSY // running
);
   logic [9:0] low;
   logic [9:0] nxt;
   logic [7:0] pd;
   logic [7:0] pf;
   logic [1:0] quiet;
   logic [4:0] bcnt;
   logic lvl_ok;
   logic trig;
   always_comb begin
      low = O_DAC_CODE & (~O_DAC_CODE + 10'h001);
      nxt = (I_CMP_ABOVE ? O_DAC_CODE : O_DAC_CODE ^ low) | (low >> 1);
      trig = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 6'h00 && I_AVS_BYTEENABLE[0]
         && I_AVS_WRITEDATA[1:0] == 2'h1 && !O_BUSY;
   end
   // pin enables may lag the registers, so only judge them once quiet
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         quiet <= 2'h0;
         bcnt <= 5'h00;
         lvl_ok <= 1'b0;
      end else begin
         quiet <= (O_PORT_DIR != pd || O_FORCED_OUT != pf) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
         // saturates, so only the first conversion of a repeat run is stepped
         bcnt <= O_BUSY ? bcnt + {4'h0, bcnt != 5'h1F} : 5'h00;
         lvl_ok <= O_INT_LEVEL > I_IPL && !I_IRQ_DISABLE;
      end
      pd <= O_PORT_DIR;
      pf <= O_FORCED_OUT;
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   trig_start_a: assert property (trig |-> ##[1:2] O_BUSY)
      else $error("trigger did not start conversion");
   sar_init_a: assert property ($rose(O_BUSY) |-> ##1 O_DAC_CODE == 10'h200)
      else $error("approximation not loaded with top bit");
   bit_step_a: assert property (O_BUSY && bcnt != 5'h00 && bcnt < 5'h08 && low > 10'h004 |=> O_DAC_CODE == $past(nxt))
      else $error("bit decision wrong");
   conv_len_a: assert property ($fell(O_BUSY) |-> bcnt == 5'h0A || bcnt == 5'h0C)
      else $error("conversion length wrong");
   forced_pins_a: assert property ((O_FORCED_OUT & 8'h97) == 8'h00)
      else $error("unexpected forced pin");
   analog_use_a: assert property (quiet == 2'h3 |-> O_ANALOG_EN == ~(O_PORT_DIR | O_FORCED_OUT))
      else $error("analog enable wrong");
   level_gate_a: assert property (O_INT_REQ && $stable(O_INT_LEVEL) |-> lvl_ok)
      else $error("request at too low a level");
   ack_clear_a: assert property (I_INT_ACK && !O_BUSY |-> ##2 !O_INT_REQ)
      else $error("request stayed after acceptance");
   cover property ($fell(O_BUSY));
   cover property (O_INT_REQ && I_INT_ACK);
   cover property (trig);
endmodule : sarc_top_assertions

bind sarc_top sarc_top_assertions i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
   .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_CMP_ABOVE(I_CMP_ABOVE), .I_IPL(I_IPL),
   .I_IRQ_DISABLE(I_IRQ_DISABLE), .I_INT_ACK(I_INT_ACK), .O_INT_REQ(O_INT_REQ), .O_INT_LEVEL(O_INT_LEVEL),
   .O_DAC_CODE(O_DAC_CODE), .O_ANALOG_EN(O_ANALOG_EN), .O_FORCED_OUT(O_FORCED_OUT),
   .O_PORT_DIR(O_PORT_DIR), .O_BUSY(O_BUSY));

// [sim/sarc_top_tb_top.sv]
// self-checking bench for the converter control
`timescale 1ns/10ps
`include "sarc_map.svh"
module sarc_top_tb_top;
   logic clk, rst, rd, wr, trg, idis, ack, sirq, above, int_req, busy, waitreq, ack_on;
   logic [5:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   logic [2:0] processor_priority_level, lvl, ch;
   logic [9:0] dac;
   logic [9:0] analog_input_voltage [8];
   logic [7:0] aen, forced, dir;
   int error_cnt, checks;
   logic [7:0] aux_tab [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h09, 8'h02, 8'h20, 8'h60};
   logic [7:0] frc_tab [8] = '{8'h28, 8'h20, 8'h20, 8'h20, 8'h20, 8'h00, 8'h40, 8'h00};
   sarc_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
      .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
      .I_CMP_ABOVE(above), .I_EXT_TRIG(trg), .I_IPL(processor_priority_level), .I_IRQ_DISABLE(idis), .I_INT_ACK(ack),
      .I_SERIAL_IRQ(sirq), .O_INT_REQ(int_req), .O_INT_LEVEL(lvl), .O_DAC_CODE(dac), .O_CHANNEL(ch),
      .O_ANALOG_EN(aen), .O_FORCED_OUT(forced), .O_PORT_DIR(dir), .O_BUSY(busy));
   sarc_partner i_far (.i_clk(clk), .i_dac(dac), .i_ch(ch), .i_en(aen), .i_req(int_req), .i_ack_on(ack_on),
      .i_vin(analog_input_voltage), .o_above(above), .o_ack(ack));
   task automatic final_report();
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   // one bus access; an edge passes after release so the next call cannot collide
   task automatic cyc(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (waitreq !== 1'b0) begin
         error_cnt++;
         final_report();
      end
      @(posedge clk);
   endtask : cyc
   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      cyc(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rchk
   task automatic conv(input logic [31:0] c);
      int n;
      n = 0;
      cyc(1'b1, `SARC_OFF_CTRL, c);
      // external trigger: pin high for one sample, then low; busy shows two edges on
      if (c[1]) begin
         trg <= 1'b1;
         @(posedge clk);
         trg <= 1'b0;
         tick(2);
      end
      while (busy !== 1'b0 && n < 30) begin
         @(posedge clk);
         n++;
      end
      if (busy !== 1'b0) begin
         error_cnt++;
         final_report();
      end
   endtask : conv
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rst, rd, wr, trg, idis, sirq, ack_on} = 7'h40;
      addr = 6'h00;
      wdata = 32'h0;
      be = 4'hF;
      processor_priority_level = 3'h0;
      analog_input_voltage = '{10'h000, 10'h3FF, 10'h1FF, 10'h155, 10'h000, 10'h2A7, 10'h000, 10'h000};
      tick(2);
      rst <= 1'b0;
      tick(2);
      chk(32'(dir), 32'h0);
      rchk(`SARC_OFF_DIR, 32'h0);
      rchk(6'h3C, 32'h0);
      conv(32'h3A5);
      rchk(6'h34, 32'h2A7);
      rchk(`SARC_OFF_CTRL, 32'h3A4);
      rchk(`SARC_OFF_INT, 32'h8);
      conv(32'h341);
      rchk(6'h28, 32'h1FC);
      rchk(6'h34, 32'h2A7);
      cyc(1'b1, `SARC_OFF_DIR, 32'h2);
      conv(32'h321);
      rchk(6'h24, 32'h0);
      cyc(1'b1, `SARC_OFF_DIR, 32'h81);
      rchk(`SARC_OFF_DIR, 32'h81);
      for (int i = 0; i < 8; i++) begin
         cyc(1'b1, `SARC_OFF_AUX, 32'(aux_tab[i]));
         tick(2);
         chk(32'(forced), 32'(frc_tab[i]));
         chk(32'(aen), {24'h00_0000, ~(frc_tab[i] | 8'h81)});
      end
      cyc(1'b1, `SARC_OFF_DIR, 32'h0);
      cyc(1'b1, `SARC_OFF_AUX, 32'h1);
      conv(32'h361);
      rchk(6'h2C, 32'h0);
      cyc(1'b1, `SARC_OFF_AUX, 32'h0);
      conv(32'h361);
      rchk(6'h2C, 32'h154);
      conv(32'h367);
      rchk(6'h2C, 32'h155);
      rchk(`SARC_OFF_CTRL, 32'h367);
      processor_priority_level <= 3'h2;
      tick(2);
      chk(32'(int_req), 32'h0);
      cyc(1'b1, `SARC_OFF_INT, 32'hB);
      tick(2);
      chk(32'({int_req, lvl}), 32'hB);
      processor_priority_level <= 3'h3;
      tick(2);
      chk(32'(int_req), 32'h0);
      processor_priority_level <= 3'h2;
      idis <= 1'b1;
      tick(2);
      chk(32'(int_req), 32'h0);
      idis <= 1'b0;
      ack_on <= 1'b1;
      tick(5);
      ack_on <= 1'b0;
      rchk(`SARC_OFF_INT, 32'h3);
      cyc(1'b1, `SARC_OFF_INT, 32'hB);
      rchk(`SARC_OFF_INT, 32'hB);
      cyc(1'b1, `SARC_OFF_INT, 32'h3);
      rchk(`SARC_OFF_INT, 32'h3);
      cyc(1'b1, `SARC_OFF_AUX, 32'h10);
      conv(32'h3A5);
      rchk(`SARC_OFF_INT, 32'h3);
      sirq <= 1'b1;
      @(posedge clk);
      sirq <= 1'b0;
      rchk(`SARC_OFF_INT, 32'hB);
      final_report();
   end
endmodule : sarc_top_tb_top

// [src/sarc_map.svh]
// register offsets, field positions, reset values and sequencing constants of the converter control
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH

`define SARC_OFF_CTRL 6'h00
`define SARC_OFF_INT 6'h04
`define SARC_OFF_DIR 6'h08
`define SARC_OFF_AUX 6'h0C
`define SARC_OFF_STAT 6'h10
`define SARC_OFF_RES_BASE 6'h20

`define SARC_CTRL_W 10
`define SARC_INT_W 4
`define SARC_AUX_W 7
`define SARC_CTRL_RST 10'h300
`define SARC_INT_RST 4'h0
`define SARC_AUX_RST 7'h00
`define SARC_DIR_RST 8'h00

`define SARC_STAT_BUSY 0
`define SARC_STAT_CH_LO 1
`define SARC_STAT_FORCE_LO 8
`define SARC_STAT_SAR_LO 16

`define SARC_SAR_INIT 10'h200
`define SARC_BIT_MSB 4'h9
`define SARC_LSB_8BIT 4'h2
`define SARC_LSB_10BIT 4'h0

`define SARC_PIN_CLK 3
`define SARC_PIN_TXD 5
`define SARC_PIN_SUB 6
`define SARC_SMODE_SYNC_INT 4'h1

`endif

// [src/sarc_pkg.sv]
// types shared by the converter control and its result memory
package sarc_pkg;

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_LOAD = 4'h2,
      S_CMP = 4'h4,
      S_STORE = 4'h8
   } sarc_state_t;

   typedef enum logic [1:0] {
      M_ONE_SHOT = 2'h0,
      M_REPEAT = 2'h1,
      M_SWEEP = 2'h2,
      M_REP_SWEEP = 2'h3
   } sarc_mode_t;

   // bit 9..0: sweep[1:0], channel[2:0], mode[1:0], res10, trig_ext, start
   typedef struct packed {
      logic [1:0] sweep;
      logic [2:0] ch;
      sarc_mode_t mode;
      logic res10;
      logic trig_ext;
      logic start;
   } sarc_ctrl_t;

   typedef struct packed {
      logic flag;
      logic [2:0] prio;
   } sarc_int_t;

   typedef struct packed {
      logic sub_ext;
      logic sub_run;
      logic ser_sel;
      logic [3:0] smode;
   } sarc_aux_t;

   typedef struct packed {
      logic en;
      logic [2:0] addr;
      logic [9:0] data;
   } sarc_wr_t;

endpackage : sarc_pkg

// [src/sarc_res_mem.sv]
// eight conversion result words with registered read data
`timescale 1ns/10ps
module sarc_res_mem (
   input wire logic i_clk,                  // core clock
   input wire logic i_rst,                  // synchronous reset, high
   input wire sarc_pkg::sarc_wr_t i_wr,     // write port
   input wire logic [2:0] i_raddr,          // read word index
   output logic [9:0] o_rdata               // read data, registered
);

   typedef struct packed {
      logic [7:0][9:0] word;
      logic [9:0] rdata;
   } sarc_mem_st_t;

   sarc_mem_st_t st;
   sarc_mem_st_t next_st;

   always_comb begin
      next_st = st;
      for (int k = 0; k < 8; k++) begin
         if (i_wr.en && (i_wr.addr == 3'(k))) begin
            next_st.word[k] = i_wr.data;
         end
      end
      next_st.rdata = st.word[i_raddr];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;

endmodule : sarc_res_mem

// [src/sarc_top.sv]
// successive-approximation converter control, result store, pin usability and interrupt flag
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sarc_map.svh"

module sarc_top (
   input wire logic I_CORE_CLK,             // core clock, 10 MHz
   input wire logic I_RST,                  // synchronous reset, high
   input wire logic [5:0] I_AVS_ADDRESS,    // byte address
   input wire logic I_AVS_READ,             // read request
   input wire logic I_AVS_WRITE,            // write request
   input wire logic [31:0] I_AVS_WRITEDATA, // write data
   input wire logic [3:0] I_AVS_BYTEENABLE, // byte lanes
   output logic [31:0] O_AVS_READDATA,      // read data
   output logic O_AVS_WAITREQUEST,          // stall, high
   input wire logic I_CMP_ABOVE,            // input voltage above comparison voltage
   input wire logic I_EXT_TRIG,             // external trigger pin level
   input wire logic [2:0] I_IPL,            // processor priority level
   input wire logic I_IRQ_DISABLE,          // processor interrupt disable flag
   input wire logic I_INT_ACK,              // request accepted, pulse
   input wire logic I_SERIAL_IRQ,           // serial unit event, pulse
   output logic O_INT_REQ,                  // request at a level above processor level
   output logic [2:0] O_INT_LEVEL,          // programmed level
   output logic [9:0] O_DAC_CODE,           // code for the comparison voltage
   output logic [2:0] O_CHANNEL,            // analog mux select
   output logic [7:0] O_ANALOG_EN,          // per pin analog input usable
   output logic [7:0] O_FORCED_OUT,         // per pin forced to output by alternate function
   output logic [7:0] O_PORT_DIR,           // per pin direction, one is output
   output logic O_BUSY                      // conversion sequence running
);

   typedef struct packed {
      sarc_pkg::sarc_state_t state;
      sarc_pkg::sarc_ctrl_t ctrl;
      sarc_pkg::sarc_int_t icr;
      sarc_pkg::sarc_aux_t aux;
      logic [7:0] dir;
      logic [7:0] aen;
      logic [7:0] forced;
      logic [9:0] sar;
      logic [3:0] bitpos;
      logic [2:0] ch;
      logic ext_prev;
      logic irq;
      logic waitreq;
      logic [1:0] bus_ph;
      logic [31:0] rdata;
      logic busy;
   } sarc_st_t;

   sarc_st_t st;
   sarc_st_t next_st;
   sarc_pkg::sarc_wr_t res_wr;
   logic [9:0] res_rdata;

   // pins that an alternate function drives, whatever the direction bits say
   function automatic logic [7:0] force_mask(input sarc_pkg::sarc_aux_t a);
      logic [7:0] m;
      m = 8'h00;
      m[`SARC_PIN_CLK] = (a.smode == `SARC_SMODE_SYNC_INT);
      case (a.smode[2:0])
         3'h1, 3'h4, 3'h5, 3'h6: m[`SARC_PIN_TXD] = 1'b1;
         default: m[`SARC_PIN_TXD] = 1'b0;
      endcase
      m[`SARC_PIN_SUB] = a.sub_run && !a.sub_ext;
      return m;
   endfunction : force_mask

   // byte lanes: a lane not enabled keeps its old bits
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // last pin of a sweep: 2, 4, 6 or 8 pins from pin 0
   function automatic logic [2:0] sweep_last(input logic [1:0] sw);
      return {sw, 1'b1};
   endfunction : sweep_last

   // word aligned access; anything else is answered but ignored
   function automatic logic aligned(input logic [5:0] a);
      return (a[1:0] == 2'h0);
   endfunction : aligned

   logic wr_go;
   logic [31:0] rd_word;
   logic trig;
   logic cmp_keep;
   logic [3:0] lsb;
   logic conv_event;
   logic sw_start;
   logic [31:0] merged;

   sarc_res_mem u_res (
      .i_clk (I_CORE_CLK),
      .i_rst (I_RST),
      .i_wr (res_wr),
      .i_raddr (I_AVS_ADDRESS[4:2]),
      .o_rdata (res_rdata)
   );

   always_comb begin
      res_wr.en = (st.state == sarc_pkg::S_STORE);
      res_wr.addr = st.ch;
      res_wr.data = st.sar;
   end

   always_comb begin
      next_st = st;
      merged = 32'h0000_0000;
      sw_start = 1'b0;
      cmp_keep = 1'b0;
      conv_event = 1'b0;
      rd_word = 32'h0000_0000;
      // last bit under test: 2 at 8-bit, 0 at 10-bit
      lsb = st.ctrl.res10 ? `SARC_LSB_10BIT : `SARC_LSB_8BIT;

      // read mux; result words come from the memory one cycle after the address
      if (aligned(I_AVS_ADDRESS)) begin
         if (I_AVS_ADDRESS[5]) begin
            rd_word = {22'h00_0000, res_rdata};
         end else begin
            case (I_AVS_ADDRESS)
               `SARC_OFF_CTRL: rd_word = {22'h00_0000, st.ctrl};
               `SARC_OFF_INT: rd_word = {28'h000_0000, st.icr};
               `SARC_OFF_DIR: rd_word = {24'h00_0000, st.dir};
               `SARC_OFF_AUX: rd_word = {25'h000_0000, st.aux};
               // status is read only; the write decode takes only offsets with address bits 5:4 clear
               `SARC_OFF_STAT: begin
                  rd_word[`SARC_STAT_BUSY] = (st.state != sarc_pkg::S_IDLE);
                  rd_word[`SARC_STAT_CH_LO +: 3] = st.ch;
                  rd_word[`SARC_STAT_FORCE_LO +: 8] = st.forced;
                  rd_word[`SARC_STAT_SAR_LO +: 10] = st.sar;
               end
               default: rd_word = 32'h0000_0000;
            endcase
         end
      end

      // fixed two wait states; a write lands on the edge that sees waitrequest low
      // three cycles per access keeps the result memory read in step with the address
      case (st.bus_ph)
         2'h0: begin
            if (I_AVS_READ || I_AVS_WRITE) begin
               next_st.bus_ph = 2'h1;
            end
         end
         2'h1: begin
            next_st.bus_ph = 2'h2;
            next_st.waitreq = 1'b0;
            next_st.rdata = I_AVS_READ ? rd_word : 32'h0000_0000;
         end
         default: begin
            next_st.bus_ph = 2'h0;
            next_st.waitreq = 1'b1;
         end
      endcase
      wr_go = I_AVS_WRITE && !st.waitreq;

      if (wr_go && (I_AVS_ADDRESS[5:4] == 2'h0) && aligned(I_AVS_ADDRESS)) begin
         case (I_AVS_ADDRESS)
            `SARC_OFF_CTRL: begin
               merged = be_merge({22'h00_0000, st.ctrl}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
               next_st.ctrl = sarc_pkg::sarc_ctrl_t'(merged[`SARC_CTRL_W-1:0]);
               sw_start = next_st.ctrl.start && !next_st.ctrl.trig_ext && I_AVS_BYTEENABLE[0];
            end
            `SARC_OFF_INT: begin
               merged = be_merge({28'h000_0000, st.icr}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
               next_st.icr = sarc_pkg::sarc_int_t'(merged[`SARC_INT_W-1:0]);
            end
            `SARC_OFF_DIR: begin
               merged = be_merge({24'h00_0000, st.dir}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
               next_st.dir = merged[7:0];
            end
            `SARC_OFF_AUX: begin
               merged = be_merge({25'h000_0000, st.aux}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
               next_st.aux = sarc_pkg::sarc_aux_t'(merged[`SARC_AUX_W-1:0]);
            end
            default: merged = 32'h0000_0000;
         endcase
      end

      // external trigger needs the pin high on one sample and low on the next
      next_st.ext_prev = I_EXT_TRIG;
      trig = sw_start ||
             (st.ctrl.start && st.ctrl.trig_ext && st.ext_prev && !I_EXT_TRIG);

      case (st.state)
         sarc_pkg::S_IDLE: begin
            if (trig) begin
               next_st.state = sarc_pkg::S_LOAD;
               // the triggering write also picks mode and channel; st.ctrl is still stale
               next_st.ch = next_st.ctrl.mode[1] ? 3'h0 : next_st.ctrl.ch;
            end
         end
         sarc_pkg::S_LOAD: begin
            next_st.sar = `SARC_SAR_INIT;
            next_st.bitpos = `SARC_BIT_MSB;
            next_st.state = sarc_pkg::S_CMP;
         end
         sarc_pkg::S_CMP: begin
            // one compare per clock; analog settling assumed within a cycle
            // disabled pin reads as below every code
            cmp_keep = I_CMP_ABOVE && st.aen[st.ch];
            next_st.sar[st.bitpos] = cmp_keep;
            if (st.bitpos == lsb) begin
               next_st.state = sarc_pkg::S_STORE;
            end else begin
               next_st.bitpos = st.bitpos - 4'h1;
               next_st.sar[st.bitpos - 4'h1] = 1'b1;
            end
         end
         sarc_pkg::S_STORE: begin
            conv_event = 1'b1;
            // repeat modes go straight back to load, no idle cycle
            next_st.state = sarc_pkg::S_LOAD;
            case (st.ctrl.mode)
               sarc_pkg::M_ONE_SHOT: begin
                  next_st.state = sarc_pkg::S_IDLE;
               end
               sarc_pkg::M_SWEEP: begin
                  if (st.ch == sweep_last(st.ctrl.sweep)) begin
                     next_st.state = sarc_pkg::S_IDLE;
                  end else begin
                     next_st.ch = st.ch + 3'h1;
                  end
               end
               sarc_pkg::M_REP_SWEEP: begin
                  next_st.ch = (st.ch == sweep_last(st.ctrl.sweep)) ? 3'h0 : st.ch + 3'h1;
               end
               default: next_st.ch = st.ch;
            endcase
            if ((next_st.state == sarc_pkg::S_IDLE) && !st.ctrl.trig_ext) begin
               next_st.ctrl.start = 1'b0;
            end
         end
         default: next_st.state = sarc_pkg::S_IDLE;
      endcase

      // clearing start stops
      // an abort between compares leaves the old result untouched
      if (!next_st.ctrl.start) begin
         next_st.state = sarc_pkg::S_IDLE;
      end

      // busy follows the state being entered, so the pin is a flop
      next_st.busy = (next_st.state != sarc_pkg::S_IDLE);

      if (I_INT_ACK) begin
         next_st.icr.flag = 1'b0;
      end
      // shared flag owner: serial event if ser_sel, else result, raises request; a set outranks any clear
      if (st.aux.ser_sel ? I_SERIAL_IRQ : conv_event) begin
         next_st.icr.flag = 1'b1;
      end

      // level compare
      // uses flag and level after this edge, so it never lags them
      next_st.irq = next_st.icr.flag && (next_st.icr.prio > I_IPL) && !I_IRQ_DISABLE;

      next_st.forced = force_mask(next_st.aux);
      next_st.aen = ~next_st.dir & ~next_st.forced;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         st.state <= sarc_pkg::S_IDLE;
         st.ctrl <= sarc_pkg::sarc_ctrl_t'(`SARC_CTRL_RST);
         st.icr <= sarc_pkg::sarc_int_t'(`SARC_INT_RST);
         st.aux <= sarc_pkg::sarc_aux_t'(`SARC_AUX_RST);
         st.dir <= `SARC_DIR_RST;
         st.aen <= 8'hFF;
         st.forced <= 8'h00;
         st.sar <= 10'h000;
         st.bitpos <= 4'h0;
         st.ch <= 3'h0;
         // trigger pin idles high; no false edge after reset
         st.ext_prev <= 1'b1;
         st.irq <= 1'b0;
         st.waitreq <= 1'b1;
         st.bus_ph <= 2'h0;
         st.rdata <= 32'h0000_0000;
         st.busy <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign O_AVS_READDATA = st.rdata;
   assign O_AVS_WAITREQUEST = st.waitreq;
   assign O_INT_REQ = st.irq;
   assign O_INT_LEVEL = st.icr.prio;
   assign O_DAC_CODE = st.sar;
   assign O_CHANNEL = st.ch;
   assign O_ANALOG_EN = st.aen;
   assign O_FORCED_OUT = st.forced;
   assign O_PORT_DIR = st.dir;
   assign O_BUSY = st.busy;

endmodule : sarc_top
